// [core/adtg_core.sv]
// Per-channel trigger selection, result-ready flags and interrupt enables.
//
// Notes on behaviour
// - One enable per channel gates both common and individual interrupts.
// - Read-only ready flag per channel, set when its result is waiting.
// - Unimplemented upper bits read zero and ignore writes.
// - Enables, ready flags and trigger fields are zero after reset.
// - Five-bit trigger field per channel, two fields per trigger register.
// - Code zero never starts a conversion.
// - Code 1 uses the common software trigger pulse.
// - Code 2 uses the level software trigger, held by software.
// - Code 4 uses the primary special event trigger of the modulator.
// - Codes 5 to 9 use primary triggers of generators 1 to 5.
// - Codes 12 and 13 use timer 1 and timer 2 period match.
// - Code 14 uses the secondary special event trigger.
// - Codes 15 to 19 use secondary triggers of generators 1 to 5.
// - Codes 22 and 23 use output compare 1 and 2.
// - Codes 24 to 28 use current-limit triggers of generators 1 to 5.
// - Code 31 is the external pin; reserved codes select nothing.
// - Level setting: 1 samples trigger as level, 0 converts on edge.
`timescale 1ns/1ps

module adtg_core #(
  parameter int NUM_CH = 22
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register port.
  input wire logic [adtg_pkg::ADDR_W-1:0] addr_in,
  input wire logic [adtg_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [adtg_pkg::DATA_W-1:0] rd_data_out,
  // Trigger events from peripherals on this clock.
  input wire logic pwm_special_in,
  input wire logic pwm_special2_in,
  input wire logic [adtg_pkg::PWM_GENS-1:0] pwm_primary_in,
  input wire logic [adtg_pkg::PWM_GENS-1:0] pwm_secondary_in,
  input wire logic [adtg_pkg::PWM_GENS-1:0] pwm_current_limit_in,
  input wire logic tmr1_match_in,
  input wire logic tmr2_match_in,
  input wire logic oc1_event_in,
  input wire logic oc2_event_in,
  // External trigger pin, asynchronous.
  input wire logic external_trigger_pin_in,
  // Converter side.
  input wire logic [NUM_CH-1:0] conv_done_in,
  input wire logic [NUM_CH-1:0] buf_read_in,
  output logic [NUM_CH-1:0] conv_start_out,
  // Interrupts.
  output logic [NUM_CH-1:0] ch_irq_out,
  output logic common_irq_out
);

  localparam int HI_W = NUM_CH - adtg_pkg::HIGH_LSB;
  localparam int NUM_TRIG = 2 * adtg_pkg::TRIG_REGS;

  // The register split into low and high halves serves 17 to 24 channels.
  if (NUM_CH <= adtg_pkg::HIGH_LSB || NUM_CH > 4 * adtg_pkg::TRIG_REGS)
  begin : g_bad_ch
    $error("NUM_CH must lie between 17 and 24");
  end

  logic [NUM_CH-1:0] channel_irq_enable_ff;
  logic [NUM_CH-1:0] channel_result_ready_ff;
  logic [NUM_CH-1:0] nxt_ready;
  logic [NUM_CH-1:0] trigger_level_sensitivity_ff;
  logic [adtg_pkg::TRG_W-1:0] channel_trigger_source_ff [NUM_CH];
  logic sw_common_ff;
  logic sw_level_ff;
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic [31:0] src_vec;
  logic [NUM_CH-1:0] sel;
  logic [NUM_CH-1:0] sel_prev_ff;
  logic [NUM_CH-1:0] start;
  logic [NUM_CH-1:0] conv_start_ff;
  logic [NUM_CH-1:0] ch_irq_ff;
  logic common_irq_ff;
  logic [NUM_CH-1:0] ready_rise;
  logic [adtg_pkg::DATA_W-1:0] trig_word [NUM_TRIG];
  logic [adtg_pkg::DATA_W-1:0] nxt_rd_data;
  logic [adtg_pkg::DATA_W-1:0] rd_data_ff;

  assign rd_data_out = rd_data_ff;
  assign conv_start_out = conv_start_ff;
  assign ch_irq_out = ch_irq_ff;
  assign common_irq_out = common_irq_ff;

  // Two-stage synchroniser for the external trigger pin.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
    end
    else
    begin
      ext_meta_ff <= external_trigger_pin_in;
      ext_sync_ff <= ext_meta_ff;
    end
  end

  // Interrupt enables; bits above the channel count are not stored.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      channel_irq_enable_ff <= '0;
    else if (wr_en_in && addr_in == adtg_pkg::OFF_IE_LOW)
      channel_irq_enable_ff[adtg_pkg::HIGH_LSB-1:0] <= wr_data_in;
    else if (wr_en_in && addr_in == adtg_pkg::OFF_IE_HIGH)
      channel_irq_enable_ff[NUM_CH-1:adtg_pkg::HIGH_LSB] <=
        wr_data_in[HI_W-1:0];
  end

  // Level sensitivity settings.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      trigger_level_sensitivity_ff <= '0;
    else if (wr_en_in && addr_in == adtg_pkg::OFF_LVL_LOW)
      trigger_level_sensitivity_ff[adtg_pkg::HIGH_LSB-1:0] <= wr_data_in;
    else if (wr_en_in && addr_in == adtg_pkg::OFF_LVL_HIGH)
      trigger_level_sensitivity_ff[NUM_CH-1:adtg_pkg::HIGH_LSB] <=
        wr_data_in[HI_W-1:0];
  end

  // Software triggers: the common one is a single-cycle pulse per write that sets its bit.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      sw_common_ff <= 1'b0;
      sw_level_ff <= 1'b0;
    end
    else
    begin
      sw_common_ff <= wr_en_in && addr_in == adtg_pkg::OFF_SW_CTRL &&
        wr_data_in[adtg_pkg::SW_COMMON_BIT];
      if (wr_en_in && addr_in == adtg_pkg::OFF_SW_CTRL)
      begin
        sw_level_ff <= wr_data_in[adtg_pkg::SW_LEVEL_BIT];
      end
    end
  end

  // Source vector indexed by trigger code; reserved codes stay zero.
  always_comb
  begin
    src_vec = '0;
    src_vec[adtg_pkg::TRG_SW_COMMON] = sw_common_ff;
    src_vec[adtg_pkg::TRG_SW_LEVEL] = sw_level_ff;
    src_vec[adtg_pkg::TRG_PWM_SPECIAL] = pwm_special_in;
    src_vec[adtg_pkg::TRG_TMR1] = tmr1_match_in;
    src_vec[adtg_pkg::TRG_TMR2] = tmr2_match_in;
    src_vec[adtg_pkg::TRG_PWM_SPECIAL2] = pwm_special2_in;
    src_vec[adtg_pkg::TRG_OC1] = oc1_event_in;
    src_vec[adtg_pkg::TRG_OC2] = oc2_event_in;
    src_vec[adtg_pkg::TRG_EXT] = ext_sync_ff;
    for (int g = 0; g < adtg_pkg::PWM_GENS; g++)
    begin
      src_vec[adtg_pkg::TRG_PWM_PRI_BASE + g] = pwm_primary_in[g];
      src_vec[adtg_pkg::TRG_PWM_SEC_BASE + g] =
        pwm_secondary_in[g];
      src_vec[adtg_pkg::TRG_PWM_CL_BASE + g] =
        pwm_current_limit_in[g];
    end
  end

  // Per-channel trigger field, selection, start and ready flag.
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    localparam logic [4:0] TRIG_ADDR = (c % 4 >= 2) ?
      5'(adtg_pkg::OFF_TRIG_HIGH_BASE + c / 4) :
      5'(adtg_pkg::OFF_TRIG_LOW_BASE + c / 4);
    localparam int FLSB = (c % 2 == 1) ? adtg_pkg::FIELD_ODD_LSB :
      adtg_pkg::FIELD_EVEN_LSB;

    always_ff @(posedge clk_in)
    begin
      if (!nrst_in)
      begin
        channel_trigger_source_ff[c] <= adtg_pkg::TRG_RST;
      end
      else if (wr_en_in && addr_in == TRIG_ADDR)
      begin
        channel_trigger_source_ff[c] <=
          wr_data_in[FLSB +: adtg_pkg::TRG_W];
      end
    end

    assign sel[c] = src_vec[channel_trigger_source_ff[c]];
    assign start[c] = trigger_level_sensitivity_ff[c] ? sel[c] :
      sel[c] & ~sel_prev_ff[c];

    // A completion in the same cycle as a buffer read keeps the flag set.
    assign nxt_ready[c] = conv_done_in[c] ? 1'b1 :
      (buf_read_in[c] ? 1'b0 : channel_result_ready_ff[c]);
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      sel_prev_ff <= '0;
      conv_start_ff <= '0;
    end
    else
    begin
      sel_prev_ff <= sel;
      conv_start_ff <= start;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      channel_result_ready_ff <= '0;
    end
    else
    begin
      channel_result_ready_ff <= nxt_ready;
    end
  end

  // Interrupts fire on the rising edge of an enabled ready flag.
  assign ready_rise = nxt_ready & ~channel_result_ready_ff;

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      ch_irq_ff <= '0;
      common_irq_ff <= 1'b0;
    end
    else
    begin
      ch_irq_ff <= ready_rise & channel_irq_enable_ff;
      common_irq_ff <= |(ready_rise & channel_irq_enable_ff);
    end
  end

  // Trigger register images; fields of absent channels read zero.
  always_comb
  begin
    for (int r = 0; r < NUM_TRIG; r++)
    begin
      trig_word[r] = adtg_pkg::DATA_RST;
    end
    for (int c = 0; c < NUM_CH; c++)
    begin
      trig_word[(c % 4 >= 2 ? adtg_pkg::TRIG_REGS : 0) + c / 4]
        [(c % 2 == 1 ? adtg_pkg::FIELD_ODD_LSB : adtg_pkg::FIELD_EVEN_LSB)
        +: adtg_pkg::TRG_W] = channel_trigger_source_ff[c];
    end
  end

  // Read multiplexer; unmapped addresses return zero.
  always_comb
  begin
    nxt_rd_data = adtg_pkg::DATA_RST;
    if (addr_in >= adtg_pkg::OFF_TRIG_LOW_BASE &&
        addr_in < adtg_pkg::OFF_LVL_LOW)
    begin
      nxt_rd_data = trig_word[4'(addr_in - adtg_pkg::OFF_TRIG_LOW_BASE)];
    end
    else
    begin
      unique case (addr_in)
        adtg_pkg::OFF_IE_LOW:
          nxt_rd_data = channel_irq_enable_ff[adtg_pkg::HIGH_LSB-1:0];
        adtg_pkg::OFF_IE_HIGH:
          nxt_rd_data[HI_W-1:0] =
            channel_irq_enable_ff[NUM_CH-1:adtg_pkg::HIGH_LSB];
        adtg_pkg::OFF_RDY_LOW:
          nxt_rd_data = channel_result_ready_ff[adtg_pkg::HIGH_LSB-1:0];
        adtg_pkg::OFF_RDY_HIGH:
          nxt_rd_data[HI_W-1:0] =
            channel_result_ready_ff[NUM_CH-1:adtg_pkg::HIGH_LSB];
        adtg_pkg::OFF_LVL_LOW:
          nxt_rd_data =
            trigger_level_sensitivity_ff[adtg_pkg::HIGH_LSB-1:0];
        adtg_pkg::OFF_LVL_HIGH:
          nxt_rd_data[HI_W-1:0] =
            trigger_level_sensitivity_ff[NUM_CH-1:adtg_pkg::HIGH_LSB];
        adtg_pkg::OFF_SW_CTRL:
          nxt_rd_data[adtg_pkg::SW_LEVEL_BIT] = sw_level_ff;
        default:
          nxt_rd_data = adtg_pkg::DATA_RST;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      rd_data_ff <= adtg_pkg::DATA_RST;
    end
    else
    begin
      rd_data_ff <= rd_en_in ? nxt_rd_data : adtg_pkg::DATA_RST;
    end
  end

  // Checks.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic [NUM_CH-1:0] code_zero;
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      code_zero[c] = channel_trigger_source_ff[c] == adtg_pkg::TRG_NONE;
    end
  end

  sequence s_ie_high_write;
    wr_en_in && addr_in == adtg_pkg::OFF_IE_HIGH;
  endsequence
  sequence s_ie_high_read;
    rd_en_in && addr_in == adtg_pkg::OFF_IE_HIGH;
  endsequence
  chk_zero_code_idle: assert property (
    (conv_start_ff & $past(code_zero)) == '0)
    else $error("zero trigger code started a conversion");
  chk_ready_sets: assert property (
    |conv_done_in |=>
    (channel_result_ready_ff & $past(conv_done_in)) == $past(conv_done_in))
    else $error("ready flag did not set on completion");
  chk_ready_clears: assert property (
    |(buf_read_in & ~conv_done_in) |=>
    (channel_result_ready_ff & $past(buf_read_in & ~conv_done_in)) == '0)
    else $error("ready flag did not clear on buffer read");
  chk_irq_masked: assert property (
    (ch_irq_ff & ~$past(channel_irq_enable_ff)) == '0)
    else $error("interrupt raised for disabled channel");
  chk_irq_on_ready: assert property (
    |(ready_rise & channel_irq_enable_ff) |=>
    common_irq_ff && ch_irq_ff == $past(ready_rise & channel_irq_enable_ff))
    else $error("enabled ready rise gave no interrupt");
  chk_high_bits_zero: assert property (
    s_ie_high_write ##1 s_ie_high_read |=>
    rd_data_ff[adtg_pkg::DATA_W-1:HI_W] == '0 &&
    rd_data_ff[HI_W-1:0] == $past(wr_data_in[HI_W-1:0], 2))
    else $error("enable high readback wrong");
  chk_level_sw_trig: assert property (
    trigger_level_sensitivity_ff[0] && sw_level_ff &&
    channel_trigger_source_ff[0] == adtg_pkg::TRG_SW_LEVEL |=>
    conv_start_ff[0])
    else $error("level software trigger did not start channel 0");
  chk_edge_once: assert property (
    !trigger_level_sensitivity_ff[0] && sel[0] && sel_prev_ff[0] |=>
    !conv_start_ff[0])
    else $error("edge mode converted on a held level");

endmodule : adtg_core

// [core/adtg_pkg.sv]
// Package of register offsets, field layouts and trigger codes.
package adtg_pkg;

  // Bus geometry.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register offsets on the plain register port.
  localparam logic [4:0] OFF_IE_LOW = 5'h00;
  localparam logic [4:0] OFF_IE_HIGH = 5'h01;
  localparam logic [4:0] OFF_RDY_LOW = 5'h02;
  localparam logic [4:0] OFF_RDY_HIGH = 5'h03;
  localparam logic [4:0] OFF_TRIG_LOW_BASE = 5'h04;
  localparam logic [4:0] OFF_TRIG_HIGH_BASE = 5'h0a;
  localparam logic [4:0] OFF_LVL_LOW = 5'h10;
  localparam logic [4:0] OFF_LVL_HIGH = 5'h11;
  localparam logic [4:0] OFF_SW_CTRL = 5'h12;
  localparam int TRIG_REGS = 6;

  // Field positions.
  localparam int HIGH_LSB = 16;
  localparam int TRG_W = 5;
  localparam int FIELD_EVEN_LSB = 0;
  localparam int FIELD_ODD_LSB = 8;
  localparam int SW_COMMON_BIT = 0;
  localparam int SW_LEVEL_BIT = 1;

  // Values after reset.
  localparam logic [4:0] TRG_RST = 5'h00;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // Trigger source codes.
  localparam logic [4:0] TRG_NONE = 5'h00;
  localparam logic [4:0] TRG_SW_COMMON = 5'h01;
  localparam logic [4:0] TRG_SW_LEVEL = 5'h02;
  localparam logic [4:0] TRG_PWM_SPECIAL = 5'h04;
  localparam logic [4:0] TRG_PWM_PRI_BASE = 5'h05;
  localparam logic [4:0] TRG_TMR1 = 5'h0c;
  localparam logic [4:0] TRG_TMR2 = 5'h0d;
  localparam logic [4:0] TRG_PWM_SPECIAL2 = 5'h0e;
  localparam logic [4:0] TRG_PWM_SEC_BASE = 5'h0f;
  localparam logic [4:0] TRG_OC1 = 5'h16;
  localparam logic [4:0] TRG_OC2 = 5'h17;
  localparam logic [4:0] TRG_PWM_CL_BASE = 5'h18;
  localparam logic [4:0] TRG_EXT = 5'h1f;
  localparam int PWM_GENS = 5;

endpackage : adtg_pkg

// [sim/tb_top.sv]
// Self-checking testbench for the converter trigger and status block.
`timescale 1ns/1ps

module tb_top;
  logic clk_in;
  logic nrst_in;
  logic [4:0] addr_in;
  logic [15:0] wr_data_in;
  logic wr_en_in;
  logic rd_en_in;
  logic [15:0] rd_data_out;
  logic [21:0] src;
  logic [21:0] conv_done_in;
  logic [21:0] buf_read_in;
  logic [21:0] conv_start_out;
  logic [21:0] ch_irq_out;
  logic common_irq_out;
  int n_mismatch = 0;
  int checks = 0;
  int cnt [3];
  int expc;

  adtg_core i_adtg_core (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out),
    .pwm_special_in(src[0]),
    .pwm_special2_in(src[1]),
    .pwm_primary_in(src[6:2]),
    .pwm_secondary_in(src[11:7]),
    .pwm_current_limit_in(src[16:12]),
    .tmr1_match_in(src[17]),
    .tmr2_match_in(src[18]),
    .oc1_event_in(src[19]),
    .oc2_event_in(src[20]),
    .external_trigger_pin_in(src[21]),
    .conv_done_in(conv_done_in),
    .buf_read_in(buf_read_in),
    .conv_start_out(conv_start_out),
    .ch_irq_out(ch_irq_out),
    .common_irq_out(common_irq_out)
  );

  initial
  begin
    clk_in = 1'b0;
    forever
      #2.5 clk_in = ~clk_in;
  end

  task stop_test;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task chk_data(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task chk_ch(input logic [21:0] got, input logic [21:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t lanes %h expected %h", $time, got, exp);
    end
  endtask : chk_ch

  task chk_cnt(input int got, input int exp, input int code);
    checks++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t code %0d starts %0d expected %0d",
               $time, code, got, exp);
    end
  endtask : chk_cnt

  task reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask : reg_wr

  task reg_rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1;
    chk_data(rd_data_out, exp);
  endtask : reg_rd

  // Source lane that each trigger code should select, zero for none.
  function automatic logic [21:0] src_of(input int c);
    logic [21:0] s;
    s = '0;
    if (c == 4)
      s[0] = 1'b1;
    else if (c >= 5 && c <= 9)
      s[c - 3] = 1'b1;
    else if (c == 12 || c == 13)
      s[c + 5] = 1'b1;
    else if (c == 14)
      s[1] = 1'b1;
    else if (c >= 15 && c <= 19)
      s[c - 8] = 1'b1;
    else if (c == 22 || c == 23)
      s[c - 3] = 1'b1;
    else if (c >= 24 && c <= 28)
      s[c - 12] = 1'b1;
    else if (c == 31)
      s[21] = 1'b1;
    return s;
  endfunction : src_of

  // Read-back value after writing all ones to each register index.
  function automatic logic [15:0] ones_back(input int a);
    if (a == 0 || a == 16)
      return 16'hffff;
    if (a == 1 || a == 17)
      return 16'h003f;
    if (a >= 4 && a <= 14)
      return 16'h1f1f;
    if (a == 18)
      return 16'h0002;
    return 16'h0000;
  endfunction : ones_back

  // Fires the source of a code; codes without one fire every source.
  task fire(input int c);
    if (c == 1)
      reg_wr(adtg_pkg::OFF_SW_CTRL, 16'h0001);
    else if (c == 2)
    begin
      reg_wr(adtg_pkg::OFF_SW_CTRL, 16'h0002);
      reg_wr(adtg_pkg::OFF_SW_CTRL, 16'h0000);
    end
    else
    begin
      @(posedge clk_in);
      src <= (src_of(c) == '0) ? '1 : src_of(c);
      @(posedge clk_in);
      src <= '0;
    end
  endtask : fire

  task watch(input int n);
    cnt = '{0, 0, 0};
    repeat (n)
    begin
      @(posedge clk_in);
      #1;
      for (int k = 0; k < 3; k++)
        if (conv_start_out[k] !== 1'b0)
          cnt[k]++;
    end
  endtask : watch

  initial
  begin
    #100000;
    n_mismatch++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    nrst_in = 1'b0;
    addr_in = '0;
    wr_data_in = '0;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    src = '0;
    conv_done_in = '0;
    buf_read_in = '0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int a = 0; a < 20; a++)
      reg_rd(a[4:0], 16'h0000);
    for (int a = 0; a < 20; a++)
    begin
      reg_wr(a[4:0], 16'hffff);
      reg_rd(a[4:0], ones_back(a));
    end
    for (int a = 0; a < 20; a++)
      reg_wr(a[4:0], 16'h0000);
    // Channels 0, 1 and 2 share each code; codes that select nothing fire every source lane.
    for (int c = 0; c < 32; c++)
    begin
      reg_wr(adtg_pkg::OFF_TRIG_LOW_BASE, {3'h0, c[4:0], 3'h0, c[4:0]});
      reg_wr(adtg_pkg::OFF_TRIG_HIGH_BASE, {11'h000, c[4:0]});
      fork
        fire(c);
        watch(10);
      join
      expc = (src_of(c) != '0 || c == 1 || c == 2) ? 1 : 0;
      for (int k = 0; k < 3; k++)
        chk_cnt(cnt[k], expc, c);
    end
    reg_wr(adtg_pkg::OFF_TRIG_LOW_BASE, 16'h0c0c);
    reg_wr(adtg_pkg::OFF_TRIG_HIGH_BASE, 16'h0000);
    reg_wr(adtg_pkg::OFF_LVL_LOW, 16'h0001);
    @(posedge clk_in);
    src <= 22'h020000;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_in);
      if (i == 3)
        src <= '0;
      #1;
      chk_ch(conv_start_out, (i == 0) ? 22'h3 : 22'h1);
    end
    @(posedge clk_in);
    #1;
    chk_ch(conv_start_out, 22'h0);
    // Level software trigger on a level-sensitive channel.
    reg_wr(adtg_pkg::OFF_TRIG_LOW_BASE, 16'h0002);
    reg_wr(adtg_pkg::OFF_SW_CTRL, 16'h0002);
    @(posedge clk_in);
    #1;
    chk_ch(conv_start_out, 22'h1);
    reg_wr(adtg_pkg::OFF_SW_CTRL, 16'h0000);
    #1;
    chk_ch(conv_start_out, 22'h1);
    @(posedge clk_in);
    #1;
    chk_ch(conv_start_out, 22'h0);
    reg_wr(adtg_pkg::OFF_TRIG_LOW_BASE, 16'h0000);
    // Write then read the upper enable half with no gap between strobes.
    @(posedge clk_in);
    addr_in <= adtg_pkg::OFF_IE_HIGH;
    wr_data_in <= 16'hffea;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1;
    chk_data(rd_data_out, 16'h002a);
    reg_wr(adtg_pkg::OFF_IE_LOW, 16'h0008);
    reg_wr(adtg_pkg::OFF_IE_HIGH, 16'h0020);
    @(posedge clk_in);
    conv_done_in <= 22'h200018;
    @(posedge clk_in);
    conv_done_in <= '0;
    #1;
    chk_ch(ch_irq_out, 22'h200008);
    chk_ch({21'h0, common_irq_out}, 22'h1);
    @(posedge clk_in);
    #1;
    chk_ch(ch_irq_out, 22'h0);
    chk_ch({21'h0, common_irq_out}, 22'h0);
    reg_rd(adtg_pkg::OFF_RDY_LOW, 16'h0018);
    reg_rd(adtg_pkg::OFF_RDY_HIGH, 16'h0020);
    @(posedge clk_in);
    buf_read_in <= 22'h000018;
    @(posedge clk_in);
    buf_read_in <= '0;
    reg_rd(adtg_pkg::OFF_RDY_LOW, 16'h0000);
    @(posedge clk_in);
    conv_done_in <= 22'h000010;
    @(posedge clk_in);
    conv_done_in <= '0;
    #1;
    chk_ch(ch_irq_out, 22'h0);
    chk_ch({21'h0, common_irq_out}, 22'h0);
    reg_rd(adtg_pkg::OFF_RDY_LOW, 16'h0010);
    // Completion and buffer read in one cycle: the completion wins.
    @(posedge clk_in);
    conv_done_in <= 22'h000008;
    buf_read_in <= 22'h000008;
    @(posedge clk_in);
    conv_done_in <= '0;
    buf_read_in <= '0;
    #1;
    chk_ch(ch_irq_out, 22'h000008);
    reg_rd(adtg_pkg::OFF_RDY_LOW, 16'h0018);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    reg_rd(adtg_pkg::OFF_IE_LOW, 16'h0000);
    reg_rd(adtg_pkg::OFF_IE_HIGH, 16'h0000);
    reg_rd(adtg_pkg::OFF_RDY_LOW, 16'h0000);
    reg_rd(adtg_pkg::OFF_LVL_LOW, 16'h0000);
    stop_test();
  end
endmodule : tb_top
